// file: pkg/bsr_defs.svh
// Constants for the bridge slave response block
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH
`define BSR_TRANS_IDLE   2'h0
`define BSR_TRANS_BUSY   2'h1
`define BSR_TRANS_NSEQ   2'h2
`define BSR_TRANS_SEQ    2'h3
`define BSR_RESP_OKAY    2'h0
`define BSR_RESP_ERROR   2'h1
`define BSR_RESP_SPLIT   2'h3
`define BSR_BURST_SINGLE 3'h0
`define BSR_BURST_INCR   3'h1
`define BSR_LEN_4        5'h04
`define BSR_LEN_8        5'h08
`define BSR_LEN_16       5'h10
`define BSR_LOCAL_AW     10
`define BSR_REG_CTRL     10'h000
`define BSR_REG_STATUS   10'h004
`define BSR_CTRL_RST     1'h0
`define BSR_WB_MIN_SEQ   5'h01
`define BSR_WB_MIN_NSEQ  5'h03
`define BSR_WB_MIN_LOCK  5'h04
`define BSR_WB_CLEAR     5'h04
`define BSR_TICK_LIMIT   2'h2
`define BSR_SPLIT_CAP    1'h1
`define BSR_MAX_PREFETCH 5'h10
`define BSR_KB_BYTES     11'h400
`endif

// file: pkg/bsr_pkg.sv
// Types for the bridge slave response block
package bsr_pkg;
    typedef enum logic [2:0] {S_IDLE, S_WAIT1, S_WAIT2, S_NOK1, S_NOK2, S_STALL} bsr_state_t;
    typedef struct packed {
        logic        sel_reg;
        logic        sel_p;
        logic        noprefetch_select;
        logic [31:0] addr;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  burst;
        logic [3:0]  master;
        logic        lock;
        logic        stall;
    } bsr_ahb_req_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [4:0]  depth;
        logic [3:0]  master;
        logic [2:0]  burst;
        logic        lock;
    } bsr_rdreq_t;
endpackage : bsr_pkg

// file: core/bsr_slave_resp.sv
// Slave-side response logic of the bus bridge
//
// Functional notes
// (R1) Register select: low 10 bits, no forward
// (R2) Secondary select forwards the full address
// (R3) Non-prefetch INCR read becomes single beat
// (R4) Otherwise both secondary selects act alike
// (R5) Unselected: OKAY with zero waits
// (R6) Write needs 1..4 free, else SPLIT
// (R7) Accepted NSEQ write: two waits, OKAY
// (R8) SEQ write zero wait, two after BUSY-full
// (R9) Availability is next-cycle free count
// (R10) BUSY and IDLE always zero-wait OKAY
// (R11) First read splits and requests prefetch
// (R12) Tag match on ready buffer means return
// (R13) New reads SPLIT; returns OKAY or ERROR
// (R14) Locked transfer flushes pending read buffer
// (R15) Early-ended return flushes its leftovers
// (R16) Read buffer returns in split order
// (R17) Flush output high per discarded word
// (R18) Master makes local accesses 32-bit single
// (R19) Prefetch depth from burst, boundary, space
// (R20) Every SPLIT is later cleared
// (R21) Stall mode holds ready low, flushes
// (R22) Two tick transitions end stall with ERROR
// (R23) Non-OKAY responses span two cycles
// (R24) Tick synchronised; count reset on ready
`timescale 1ns/1ps
`include "bsr_defs.svh"
module bsr_slave_resp
    import bsr_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Primary slave port
    input  wire bsr_ahb_req_t req,
    input  wire logic         hready_in,
    input  wire logic [31:0]  hwdata,
    output logic              hready_resp,
    output logic [1:0]        hresp,
    output logic [31:0]       hrdata,
    output logic [15:0]       hsplit,
    // Sidebands
    input  wire logic         sttick,
    output logic              sflush,
    // Write buffer push side
    input  wire logic [4:0]   wb_free,
    output logic              wb_push,
    output logic [31:0]       wb_word,
    // Read request and read buffer pop side
    output logic              rd_req,
    output bsr_rdreq_t        rd_req_info,
    input  wire logic         rb_ready,
    input  wire logic         rb_empty,
    input  wire logic [3:0]   rb_tag,
    input  wire logic [31:0]  rb_data,
    input  wire logic         rb_err,
    input  wire logic [4:0]   rb_left,
    input  wire logic [4:0]   rb_free,
    output logic              rb_pop
);
    localparam logic       split_capable_param      = `BSR_SPLIT_CAP;
    localparam logic [4:0] max_prefetch_depth_param = `BSR_MAX_PREFETCH;

    function automatic logic [15:0] bsr_onehot(input logic [3:0] m);
        bsr_onehot = 16'h0001 << m;
    endfunction : bsr_onehot

    function automatic logic [4:0] bsr_depth(input logic np, input logic [2:0] b,
                                             input logic [9:0] a, input logic [4:0] fr);
        logic [8:0] bnd;
        logic [8:0] d;
        bnd = 9'((`BSR_KB_BYTES - {1'b0, a}) >> 2);
        case (b[2:1])
            2'h1:    d = {4'h0, `BSR_LEN_4};
            2'h2:    d = {4'h0, `BSR_LEN_8};
            2'h3:    d = {4'h0, `BSR_LEN_16};
            default: d = (b[0] && !np) ? {4'h0, max_prefetch_depth_param} : 9'h001;
        endcase
        if (b[0] && d > bnd) d = bnd;
        if (d > {4'h0, max_prefetch_depth_param}) d = {4'h0, max_prefetch_depth_param};
        if (d > {4'h0, fr}) d = {4'h0, fr};
        if (d == 9'h000) d = 9'h001;
        bsr_depth = d[4:0];
    endfunction : bsr_depth

    bsr_state_t   state_ff;
    bsr_state_t   nxt_state;
    bsr_ahb_req_t dp_ff;
    logic [1:0]   resp_ff;
    logic [1:0]   nxt_resp;
    logic [31:0]  hrdata_ff;
    logic [15:0]  hsplit_ff;
    logic [15:0]  wsplit_ff;
    logic [15:0]  rpend_ff;
    logic         dpw_ff;
    logic         regw_ff;
    logic         busy_ff;
    logic         full_ff;
    logic         ret_act_ff;
    logic         part_ff;
    logic         flush_all_ff;
    logic         ctrl_ff;
    logic         rd_req_ff;
    bsr_rdreq_t   rd_info_ff;
    logic         tk1_ff;
    logic         tk2_ff;
    logic         tk3_ff;
    logic [1:0]   tcnt_ff;

    // Address phase qualification
    wire        can_take   = hready_in && (state_ff == S_IDLE || state_ff == S_NOK2);
    wire        active     = req.trans == `BSR_TRANS_NSEQ || req.trans == `BSR_TRANS_SEQ;
    wire        sel_sec    = req.sel_p || req.noprefetch_select;
    wire        acc_sec    = can_take && active && sel_sec;
    wire        acc_reg    = can_take && active && req.sel_reg && !sel_sec;
    wire        stall_mode = req.stall || !split_capable_param || ctrl_ff;
    wire [15:0] own        = bsr_onehot(req.master);

    // Write acceptance
    wire [4:0]  wb_avail = wb_free - {4'h0, wb_push}; // R9
    wire [4:0]  wb_min   = req.trans != `BSR_TRANS_NSEQ ? `BSR_WB_MIN_SEQ :
                           req.lock ? `BSR_WB_MIN_LOCK : `BSR_WB_MIN_NSEQ;
    wire        wr_ok    = wb_avail >= wb_min;
    wire        wr_wait  = req.trans == `BSR_TRANS_NSEQ || (busy_ff && full_ff);

    // Read classification
    wire        is_ret    = rb_ready && rb_tag == req.master && !flush_all_ff;
    wire        stall_ret = rb_ready && rb_tag == dp_ff.master && !flush_all_ff;
    wire        others    = (rpend_ff & ~own) != 16'h0000;
    wire        lock_flush = acc_sec && (req.lock || stall_mode) && !is_ret
                           && (others || (stall_mode && !rb_empty));

    // Decisions for a secondary access, stalling or not
    wire        dec       = acc_sec && !stall_mode;
    wire        go_stall  = acc_sec && stall_mode;
    wire        wr_split  = dec && req.write && !wr_ok;
    wire        wr_zero   = dec && req.write && wr_ok && !wr_wait;
    wire        go_wait   = dec && req.write && wr_ok && wr_wait;
    wire        rd_ret    = dec && !req.write && is_ret;
    wire        rd_full   = dec && !req.write && !is_ret && wb_free == 5'h00;
    wire        rd_new    = dec && !req.write && !is_ret && wb_free != 5'h00;
    wire        go_split  = wr_split || rd_full || rd_new;
    wire        tmo       = tcnt_ff == `BSR_TICK_LIMIT;
    wire        stall_pop = state_ff == S_STALL && !dp_ff.write && stall_ret && !tmo;
    wire        tick_edge = tk2_ff ^ tk3_ff;

    // Local register read mux
    wire [31:0] reg_rd = req.addr[`BSR_LOCAL_AW-1:0] == `BSR_REG_CTRL ?
                         {31'h0, ctrl_ff} :
                         req.addr[`BSR_LOCAL_AW-1:0] == `BSR_REG_STATUS ?
                         {9'h000, rpend_ff, rb_ready, !rb_empty, wb_free} : 32'h0;

    // Split set and clear events
    wire        wclr   = wb_free >= `BSR_WB_CLEAR;
    wire [15:0] rclr   = rb_ready ? (rpend_ff & bsr_onehot(rb_tag)) : 16'h0000;
    wire [15:0] fclr   = lock_flush ? rpend_ff : 16'h0000;
    wire [15:0] wset   = (wr_split || rd_full) ? own : 16'h0000;
    wire [15:0] rset   = rd_new ? own : 16'h0000;
    wire        ret_end = can_take && ret_act_ff && !(req.master == dp_ff.master
                          && (req.trans == `BSR_TRANS_SEQ || req.trans == `BSR_TRANS_BUSY));

    // State machine
    always_comb begin
        nxt_state = state_ff;
        nxt_resp  = resp_ff;
        case (state_ff)
            S_IDLE, S_NOK2: begin
                nxt_state = S_IDLE;
                if (can_take && go_stall) begin
                    nxt_state = S_STALL; // R21
                end else if (can_take && go_split) begin
                    nxt_state = S_NOK1; // R6 R13
                    nxt_resp  = `BSR_RESP_SPLIT;
                end else if (rd_ret && rb_err) begin
                    nxt_state = S_NOK1; // R13
                    nxt_resp  = `BSR_RESP_ERROR;
                end else if (go_wait) begin
                    nxt_state = S_WAIT1; // R7 R8
                end
            end
            S_WAIT1: nxt_state = S_WAIT2;
            S_WAIT2: nxt_state = S_IDLE;
            S_NOK1:  nxt_state = S_NOK2; // R23
            S_STALL: begin
                if (tmo) begin
                    nxt_state = S_NOK1; // R22
                    nxt_resp  = `BSR_RESP_ERROR;
                end else if (dp_ff.write && wb_avail >= `BSR_WB_MIN_NSEQ) begin
                    nxt_state = S_WAIT1;
                end else if (stall_pop) begin
                    nxt_state = rb_err ? S_NOK1 : S_IDLE;
                    nxt_resp  = `BSR_RESP_ERROR;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    // Response outputs
    assign hready_resp = state_ff == S_IDLE || state_ff == S_NOK2; // R5 R10
    assign hresp       = (state_ff == S_NOK1 || state_ff == S_NOK2) ? resp_ff
                                                                    : `BSR_RESP_OKAY;
    assign hrdata      = hrdata_ff;
    assign hsplit      = hsplit_ff;
    assign rd_req      = rd_req_ff;
    assign rd_req_info = rd_info_ff;

    // Write buffer pushes: control, address, then data; zero-wait SEQ writes push data only
    assign wb_push = state_ff == S_WAIT1 || state_ff == S_WAIT2 || dpw_ff; // R7
    assign wb_word = state_ff == S_WAIT1 ?
                     {23'h0, dp_ff.lock, dp_ff.master, dp_ff.burst, dp_ff.write} :
                     state_ff == S_WAIT2 ? dp_ff.addr : hwdata;

    // Read buffer pops and discards
    assign rb_pop = rd_ret || stall_pop; // R12 R16
    assign sflush = (flush_all_ff && !rb_empty) || (part_ff && rb_left != 5'h00); // R14 R15 R17

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
            resp_ff  <= `BSR_RESP_OKAY;
            dp_ff    <= '0;
        end else begin
            state_ff <= nxt_state;
            resp_ff  <= nxt_resp;
            if (can_take) begin
                dp_ff <= req;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dpw_ff  <= 1'h0;
            regw_ff <= 1'h0;
            busy_ff <= 1'h0;
            full_ff <= 1'h0;
        end else begin
            dpw_ff  <= wr_zero || state_ff == S_WAIT2;
            regw_ff <= acc_reg && req.write; // R1
            if (can_take && sel_sec && req.write) begin
                busy_ff <= req.trans == `BSR_TRANS_BUSY;
            end
            if (dpw_ff) begin
                full_ff <= wb_free == 5'h01; // R8
            end
        end
    end

    // Local register write in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `BSR_CTRL_RST;
        end else if (regw_ff && dp_ff.addr[`BSR_LOCAL_AW-1:0] == `BSR_REG_CTRL) begin
            ctrl_ff <= hwdata[0]; // R1
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata_ff <= 32'h0;
        end else if (acc_reg && !req.write) begin
            hrdata_ff <= reg_rd; // R1
        end else if (rb_pop) begin
            hrdata_ff <= rb_data;
        end
    end

    // Split bookkeeping and clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hsplit_ff <= 16'h0000;
            wsplit_ff <= 16'h0000;
            rpend_ff  <= 16'h0000;
        end else begin
            hsplit_ff <= (wclr ? wsplit_ff : 16'h0000) | rclr | fclr; // R20
            wsplit_ff <= (wclr ? 16'h0000 : wsplit_ff) | wset; // R20
            rpend_ff  <= (rpend_ff & ~rclr & ~fclr) | rset; // R11 R16
        end
    end

    // Read request towards the master side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_req_ff  <= 1'h0;
            rd_info_ff <= '0;
        end else begin
            rd_req_ff <= rd_new || (go_stall && !req.write && !is_ret); // R2 R11
            if (acc_sec) begin
                rd_info_ff.addr   <= req.addr; // R2
                rd_info_ff.depth  <= bsr_depth(req.noprefetch_select, req.burst,
                                               req.addr[9:0], rb_free); // R3 R4 R19
                rd_info_ff.master <= req.master;
                rd_info_ff.burst  <= req.burst;
                rd_info_ff.lock   <= req.lock;
            end
        end
    end

    // Flush control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ret_act_ff   <= 1'h0;
            part_ff      <= 1'h0;
            flush_all_ff <= 1'h0;
        end else begin
            if (can_take) begin
                ret_act_ff <= rd_ret || (ret_act_ff && req.trans == `BSR_TRANS_BUSY);
            end
            if (ret_end) begin
                part_ff <= 1'h1; // R15
            end else if (rb_left == 5'h00) begin
                part_ff <= 1'h0;
            end
            if (lock_flush) begin
                flush_all_ff <= 1'h1; // R14 R21
            end else if (rb_empty) begin
                flush_all_ff <= 1'h0;
            end
        end
    end

    // Tick synchroniser and stall timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tk1_ff  <= 1'h0;
            tk2_ff  <= 1'h0;
            tk3_ff  <= 1'h0;
            tcnt_ff <= 2'h0;
        end else begin
            tk1_ff <= sttick; // R24
            tk2_ff <= tk1_ff;
            tk3_ff <= tk2_ff;
            if (hready_resp) begin
                tcnt_ff <= 2'h0; // R24
            end else if (state_ff == S_STALL && tick_edge && !tmo) begin
                tcnt_ff <= tcnt_ff + 2'h1; // R22
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_two_waits;
        !hready_resp && hresp == `BSR_RESP_OKAY ##1 !hready_resp ##1 hready_resp;
    endsequence
    sequence s_nok(logic [1:0] code);
        !hready_resp && hresp == code ##1 hready_resp && hresp == code;
    endsequence

    AST_UNSEL_OKAY: assert property (can_take && !req.sel_reg && !sel_sec // R5
        |=> hready_resp && hresp == `BSR_RESP_OKAY) else $error("unselected not OKAY");
    AST_IDLE_BUSY: assert property (can_take && !active // R10
        |=> hready_resp && hresp == `BSR_RESP_OKAY) else $error("idle or busy waited");
    AST_NSEQ_WAITS: assert property (go_wait && !req.lock // R7
        |=> s_two_waits ##0 wb_push) else $error("NSEQ write waits wrong");
    AST_WR_SPLIT: assert property (wr_split |=> s_nok(`BSR_RESP_SPLIT)) // R6
        else $error("write not split");
    AST_NEW_READ: assert property (rd_new // R11
        |=> rd_req ##0 s_nok(`BSR_RESP_SPLIT)) else $error("new read not split");
    AST_NP_SINGLE: assert property (rd_new && req.noprefetch_select && !req.sel_p // R3
        && req.burst == `BSR_BURST_INCR |=> rd_req_info.depth == 5'h01)
        else $error("non-prefetch depth not one");
    AST_REG_LOCAL: assert property (acc_reg |=> !rd_req) // R1
        else $error("local access forwarded");
    AST_LOCK_FLUSH: assert property (lock_flush && !rb_empty |=> sflush) // R14
        else $error("locked transfer did not flush");
    AST_TIMEOUT: assert property (state_ff == S_STALL && tmo // R22
        |=> s_nok(`BSR_RESP_ERROR)) else $error("stall timeout missing");
    AST_WSPLIT_CLR: assert property (wsplit_ff != 16'h0000 && wclr // R20
        |=> hsplit != 16'h0000) else $error("write split not cleared");
    AST_NOK_HOLD: assert property (!hready_resp && hresp != `BSR_RESP_OKAY // R23
        |=> hready_resp && hresp == $past(hresp)) else $error("non-OKAY not two cycles");
    AST_STALL_LOW: assert property (go_stall |=> !hready_resp) // R21
        else $error("stall mode ready high");

endmodule : bsr_slave_resp

// file: tb/bsr_buf_model.sv
// Buffer-side partner model: write buffer level and read buffer queue
`timescale 1ns/1ps
module bsr_buf_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench controls
    input  wire logic        wb_set,
    input  wire logic [4:0]  wb_val,
    input  wire logic        rb_load,
    input  wire logic [3:0]  ld_tag,
    input  wire logic [4:0]  ld_cnt,
    input  wire logic        ld_err,
    // Block side
    input  wire logic        wb_push,
    input  wire logic        rb_pop,
    input  wire logic        sflush,
    output logic [4:0]       wb_free,
    output logic             rb_ready,
    output logic             rb_empty,
    output logic [3:0]       rb_tag,
    output logic [31:0]      rb_data,
    output logic             rb_err,
    output logic [4:0]       rb_left,
    output logic [4:0]       rb_free
);
    logic [31:0] last_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_free <= 5'h10;
            rb_left <= 5'h00;
            rb_tag  <= 4'h0;
            rb_err  <= 1'b0;
            last_ff <= 32'h0;
        end else begin
            if (wb_set)
                wb_free <= wb_val;
            else if (wb_push)
                wb_free <= wb_free - 5'h01;
            if (rb_load) begin
                rb_left <= ld_cnt;
                rb_tag  <= ld_tag;
                rb_err  <= ld_err;
            end else if ((rb_pop || sflush) && !rb_empty)
                rb_left <= rb_left - 5'h01;
            if (!rb_empty)
                last_ff <= rb_data;
        end
    end
    // Ready whenever the queue still holds at least one word
    assign rb_empty = (rb_left == 5'h00);
    assign rb_ready = !rb_empty;
    assign rb_free  = 5'h11 - rb_left;
    // Drained queue shows no stale word
    assign rb_data  = rb_empty ? ~last_ff : {8'hd0, 19'h0, rb_left};
endmodule : bsr_buf_model

// file: tb/tb.sv
// Self-checking bench for the bridge slave response block
`timescale 1ns/1ps
`include "bsr_defs.svh"
module tb;
    import bsr_pkg::*;
    logic clk, rst, hready_in, hready_resp, sttick, sflush, wb_push, rd_req, rb_pop;
    logic rb_ready, rb_empty, rb_err, wb_set, rb_load, ld_err;
    bsr_ahb_req_t req;
    bsr_rdreq_t   rd_req_info;
    logic [31:0]  hwdata, hrdata, wb_word, rb_data;
    logic [15:0]  hsplit;
    logic [1:0]   hresp;
    logic [4:0]   wb_free, rb_left, rb_free, wb_val, ld_cnt;
    logic [3:0]   rb_tag, ld_tag;
    int n_errors, n_checks;
    assign hready_in = hready_resp;
    bsr_slave_resp u_dut (.clk(clk), .rst(rst), .req(req), .hready_in(hready_in),
        .hwdata(hwdata), .hready_resp(hready_resp), .hresp(hresp), .hrdata(hrdata),
        .hsplit(hsplit), .sttick(sttick), .sflush(sflush), .wb_free(wb_free),
        .wb_push(wb_push), .wb_word(wb_word), .rd_req(rd_req), .rd_req_info(rd_req_info),
        .rb_ready(rb_ready), .rb_empty(rb_empty), .rb_tag(rb_tag), .rb_data(rb_data),
        .rb_err(rb_err), .rb_left(rb_left), .rb_free(rb_free), .rb_pop(rb_pop));
    bsr_buf_model u_buf (.clk(clk), .rst(rst), .wb_set(wb_set), .wb_val(wb_val),
        .rb_load(rb_load), .ld_tag(ld_tag), .ld_cnt(ld_cnt), .ld_err(ld_err),
        .wb_push(wb_push), .rb_pop(rb_pop), .sflush(sflush), .wb_free(wb_free),
        .rb_ready(rb_ready), .rb_empty(rb_empty), .rb_tag(rb_tag), .rb_data(rb_data),
        .rb_err(rb_err), .rb_left(rb_left), .rb_free(rb_free));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rsp(input logic rdy, input logic [1:0] code);
        chk({31'h0, hready_resp}, {31'h0, rdy});
        chk({30'h0, hresp}, {30'h0, code});
    endtask : rsp
    task automatic nxt;
        @(posedge clk);
        #1;
    endtask : nxt
    function automatic bsr_ahb_req_t mk(input logic [2:0] s, input logic [31:0] a,
        input logic [1:0] t, input logic w, input logic [2:0] b, input logic [3:0] m,
        input logic lk, input logic st);
        return '{s[2], s[1], s[0], a, t, w, b, m, lk, st};
    endfunction : mk
    // Drives the address phase and returns before the take edge; take then waits for that edge and returns in the first data cycle
    task automatic start(input bsr_ahb_req_t r);
        @(posedge clk);
        req <= r;
        #1;
    endtask : start
    task automatic take(input logic [31:0] wd);
        @(posedge clk);
        req    <= '0;
        hwdata <= wd;
        #1;
    endtask : take
    task automatic set_wb(input logic [4:0] v);
        @(posedge clk);
        wb_set <= 1'b1;
        wb_val <= v;
        @(posedge clk);
        wb_set <= 1'b0;
        #1;
    endtask : set_wb
    task automatic load_rb(input logic [3:0] t, input logic [4:0] c, input logic e);
        @(posedge clk);
        rb_load <= 1'b1;
        ld_tag  <= t;
        ld_cnt  <= c;
        ld_err  <= e;
        @(posedge clk);
        rb_load <= 1'b0;
        #1;
    endtask : load_rb
    task automatic wait_split(input int m);
        bit f;
        f = 0;
        for (int i = 0; i < 30 && !f; i++) begin
            nxt();
            if (hsplit[m] === 1'b1)
                f = 1;
        end
        chk({31'h0, f}, 32'h1);
        if (!f)
            give_verdict();
    endtask : wait_split
    task automatic t_reg;
        set_wb(5'h0c);
        start(mk(3'h4, 32'hffff_f004, `BSR_TRANS_NSEQ, 1'b0, 3'h0, 4'h1, 1'b0, 1'b0));
        take(32'h0);
        rsp(1'b1, `BSR_RESP_OKAY);
        chk({31'h0, rd_req}, 32'h0);
        chk({27'h0, hrdata[4:0]}, 32'h0c);
        set_wb(5'h10);
    endtask : t_reg
    task automatic t_idle;
        start(mk(3'h0, 32'h100, `BSR_TRANS_NSEQ, 1'b0, 3'h0, 4'h1, 1'b0, 1'b0));
        take(32'h0);
        rsp(1'b1, `BSR_RESP_OKAY);
        chk({31'h0, rd_req}, 32'h0);
        start(mk(3'h2, 32'h100, `BSR_TRANS_BUSY, 1'b1, 3'h1, 4'h1, 1'b0, 1'b0));
        take(32'h0);
        rsp(1'b1, `BSR_RESP_OKAY);
        chk({31'h0, wb_push}, 32'h0);
    endtask : t_idle
    task automatic t_write;
        start(mk(3'h1, 32'h2000_0040, `BSR_TRANS_NSEQ, 1'b1, 3'h1, 4'h1, 1'b0, 1'b0));
        take(32'h1234_5678);
        rsp(1'b0, `BSR_RESP_OKAY);
        chk({31'h0, wb_push}, 32'h1);
        nxt();
        rsp(1'b0, `BSR_RESP_OKAY);
        chk(wb_word, 32'h2000_0040);
        nxt();
        rsp(1'b1, `BSR_RESP_OKAY);
        chk(wb_word, 32'h1234_5678);
    endtask : t_write
    task automatic t_wsplit;
        set_wb(5'h00);
        start(mk(3'h2, 32'h2000_0080, `BSR_TRANS_NSEQ, 1'b1, 3'h0, 4'h5, 1'b0, 1'b0));
        take(32'h0);
        rsp(1'b0, `BSR_RESP_SPLIT);
        nxt();
        rsp(1'b1, `BSR_RESP_SPLIT);
        set_wb(5'h04);
        wait_split(5);
        set_wb(5'h10);
    endtask : t_wsplit
    task automatic t_newrd(input logic [2:0] s, input logic [31:0] a, input logic [2:0] b,
        input logic [3:0] m, input logic [4:0] dep);
        start(mk(s, a, `BSR_TRANS_NSEQ, 1'b0, b, m, 1'b0, 1'b0));
        take(32'h0);
        rsp(1'b0, `BSR_RESP_SPLIT);
        chk({31'h0, rd_req}, 32'h1);
        chk(rd_req_info.addr, a);
        chk({27'h0, rd_req_info.depth}, {27'h0, dep});
        nxt();
        rsp(1'b1, `BSR_RESP_SPLIT);
    endtask : t_newrd
    task automatic t_ret(input logic [3:0] m, input logic e);
        load_rb(m, 5'h01, e);
        wait_split(m);
        start(mk(3'h2, 32'h4000_0000, `BSR_TRANS_NSEQ, 1'b0, 3'h0, m, 1'b0, 1'b0));
        chk({31'h0, rb_pop}, 32'h1);
        take(32'h0);
        rsp(!e, e ? `BSR_RESP_ERROR : `BSR_RESP_OKAY);
        if (!e)
            chk(hrdata, 32'hd000_0001);
        nxt();
        if (e)
            rsp(1'b1, `BSR_RESP_ERROR);
    endtask : t_ret
    // Return burst ends after one beat; two leftovers must be discarded
    task automatic t_part;
        int n;
        n = 0;
        load_rb(4'h9, 5'h03, 1'b0);
        start(mk(3'h2, 32'h4000_0300, `BSR_TRANS_NSEQ, 1'b0, 3'h1, 4'h9, 1'b0, 1'b0));
        take(32'h0);
        for (int i = 0; i < 8; i++) begin
            if (sflush === 1'b1)
                n++;
            nxt();
        end
        chk(n, 2);
        chk({27'h0, rb_left}, 32'h0);
    endtask : t_part
    task automatic t_lock;
        int n;
        n = 0;
        t_newrd(3'h2, 32'h4000_0200, 3'h0, 4'h6, 5'h01);
        load_rb(4'h4, 5'h03, 1'b0);
        start(mk(3'h2, 32'h2000_0100, `BSR_TRANS_NSEQ, 1'b1, 3'h0, 4'h7, 1'b1, 1'b0));
        take(32'h5);
        for (int i = 0; i < 30; i++) begin
            if (sflush === 1'b1)
                n++;
            nxt();
        end
        chk(n, 3);
    endtask : t_lock
    task automatic t_stall;
        int k;
        k = -1;
        start(mk(3'h2, 32'h5000_0000, `BSR_TRANS_NSEQ, 1'b0, 3'h0, 4'h8, 1'b0, 1'b1));
        take(32'h0);
        rsp(1'b0, `BSR_RESP_OKAY);
        for (int i = 0; i < 40 && k < 0; i++) begin
            @(posedge clk);
            if (i == 3 || i == 8)
                sttick <= ~sttick;
            #1;
            if (hresp === `BSR_RESP_ERROR)
                k = i;
            else
                chk({31'h0, hready_resp}, 32'h0);
        end
        chk({31'h0, k > 8 && k < 16}, 32'h1);
        chk({31'h0, hready_resp}, 32'h0);
        nxt();
        rsp(1'b1, `BSR_RESP_ERROR);
    endtask : t_stall
    initial begin
        n_errors = 0;
        n_checks = 0;
        rst = 1'b1;
        req = '0;
        hwdata = 32'h0;
        sttick = 1'b0;
        wb_set = 1'b0;
        wb_val = 5'h0;
        rb_load = 1'b0;
        ld_tag = 4'h0;
        ld_cnt = 5'h0;
        ld_err = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reg();
        t_idle();
        t_write();
        t_wsplit();
        t_newrd(3'h2, 32'h4000_03f8, 3'h3, 4'h2, 5'h02);
        t_newrd(3'h1, 32'h4000_0100, 3'h1, 4'h3, 5'h01);
        t_newrd(3'h1, 32'h4000_0100, 3'h3, 4'h4, 5'h04);
        t_ret(4'h2, 1'b0);
        t_ret(4'h3, 1'b1);
        t_part();
        t_lock();
        t_stall();
        give_verdict();
    end
endmodule : tb
